// *** core/rpf_defs.svh ***
// Register offsets, field positions, reset values for the raster pixel format block
`ifndef RPF_DEFS_SVH
`define RPF_DEFS_SVH
`define RPF_ADDR_ATTR      32'h8003_0024
`define RPF_ADDR_PIXMODE   32'h8003_0054
`define RPF_ADDR_PANEL_OUT 32'h8003_0058
`define RPF_ADDR_PANEL_CTL 32'h8003_005c
`define RPF_ADDR_BIAS_RATE 32'h8003_0214
`define RPF_ADDR_FIFOLVL   32'h8003_0234
`define RPF_ATTR_EN_BIT    0
`define RPF_ATTR_PIF_BIT   13
`define RPF_PM_RB_BIT      15
`define RPF_PM_DS_BIT      14
`define RPF_PM_C_LSB       10
`define RPF_PM_M_LSB       6
`define RPF_PM_S_LSB       3
`define RPF_PM_P_LSB       0
`define RPF_PO_DIR_BIT     8
`define RPF_PC_CNT_LSB     16
`define RPF_PC_STRB_BEGIN_LSB 20
`define RPF_PIXMODE_RST    16'h0000
`define RPF_BIAS_RATE_RST  32'h0000_0000
`define RPF_FIFOLVL_RST    32'h0000_0010
`define RPF_PANEL_CTL_RST  32'h0000_0000
`define RPF_SYNC_STAGES    3
`endif

// *** core/rpf_pkg.sv ***
// Types shared by the raster pixel format block
package rpf_pkg;
  typedef enum logic [2:0] {
    RPF_CLR_LUT, RPF_CLR_888, RPF_CLR_565, RPF_CLR_555, RPF_CLR_GRAY, RPF_CLR_RSVD
  } rpf_color_e;
  typedef enum logic [3:0] {
    RPF_BL_OFF, RPF_BL_AND, RPF_BL_OR, RPF_BL_XOR, RPF_BL_BKGND, RPF_BL_OFS_SINGLE,
    RPF_BL_OFS_888, RPF_BL_DIM_SINGLE, RPF_BL_BRIGHT_SINGLE, RPF_BL_DIM_888,
    RPF_BL_BRIGHT_888, RPF_BL_UNDEF
  } rpf_blink_e;
  typedef enum logic [2:0] {
    RPF_SH_1PIX24, RPF_SH_1PIX18, RPF_SH_2PIX9, RPF_SH_4PIX4, RPF_SH_8PIX2,
    RPF_SH_PACK3, RPF_SH_PACK3_DUAL
  } rpf_shift_e;
  typedef enum logic [2:0] {
    RPF_BPP_OFF, RPF_BPP_4, RPF_BPP_8, RPF_BPP_16, RPF_BPP_24P, RPF_BPP_32, RPF_BPP_BAD
  } rpf_bpp_e;
  typedef enum logic [1:0] {
    RPF_PP_IDLE = 2'b01,
    RPF_PP_RUN  = 2'b10
  } rpf_pp_state_e;
endpackage

// *** core/rpf_panel_if.sv ***
// Carrier between the register side and the panel cycle engine
`timescale 1ns/10ps
interface rpf_panel_if #(parameter int CNT_W = 4);
  logic             start;
  logic             is_read;
  logic [7:0]       wr_byte;
  logic [CNT_W-1:0] preload;
  logic [CNT_W-1:0] strobe_begin_value;
  logic             step;
  logic [7:0]       pin_byte;
  logic             busy;
  logic             strobe;
  logic             drive;
  logic [7:0]       rd_byte;
  logic             rd_valid;
  modport ctl  (output start, is_read, wr_byte, preload, strobe_begin_value, step, pin_byte,
                input busy, strobe, drive, rd_byte, rd_valid);
  modport port (input start, is_read, wr_byte, preload, strobe_begin_value, step, pin_byte,
                output busy, strobe, drive, rd_byte, rd_valid);
endinterface

// *** core/rpf_panel_port.sv ***
// Panel bus cycle engine: down counter, strobe timing, read capture
`timescale 1ns/10ps
module rpf_panel_port #(
  parameter int CNT_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  rpf_panel_if.port pp
);
  import rpf_pkg::*;

  typedef struct packed {
    rpf_pp_state_e    state;
    logic [CNT_W-1:0] cnt;
    logic             is_read;
    logic [7:0]       byte_out;
    logic             strobe;
    logic             drive;
    logic [7:0]       rd_byte;
    logic             rd_valid;
  } rpf_pp_s;

  rpf_pp_s st;
  rpf_pp_s next_st;
  logic [CNT_W-1:0] dec;

  always_comb begin
    next_st = st;
    dec = st.cnt - 1'b1;
    next_st.rd_valid = 1'b0;
    case (st.state)
      RPF_PP_IDLE: begin
        if (pp.start) begin
          next_st.state    = RPF_PP_RUN;
          next_st.cnt      = pp.preload;
          next_st.is_read  = pp.is_read;
          next_st.byte_out = pp.wr_byte;
          next_st.drive    = !pp.is_read;
          next_st.strobe   = (pp.preload <= pp.strobe_begin_value) && (pp.preload != '0);
        end
      end
      RPF_PP_RUN: begin
        if (pp.step) begin
          if (st.cnt == '0) begin
            // Data was held through the zero count; release now
            next_st.state  = RPF_PP_IDLE;
            next_st.drive  = 1'b0;
            next_st.strobe = 1'b0;
          end else begin
            next_st.cnt    = dec;
            next_st.strobe = (dec <= pp.strobe_begin_value) && (dec != '0);
            if (st.strobe && dec == '0 && st.is_read) begin
              next_st.rd_byte  = pp.pin_byte;
              next_st.rd_valid = 1'b1;
            end
          end
        end
      end
      default: begin
        next_st.state  = RPF_PP_IDLE;
        next_st.drive  = 1'b0;
        next_st.strobe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{state: RPF_PP_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign pp.busy     = (st.state != RPF_PP_IDLE);
  assign pp.strobe   = st.strobe;
  assign pp.drive    = st.drive;
  assign pp.rd_byte  = st.rd_byte;
  assign pp.rd_valid = st.rd_valid;
endmodule // rpf_panel_port

// *** core/rpf_top.sv ***
// Raster pixel format, FIFO refill, AC bias and panel port with APB registers
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "rpf_defs.svh"

module rpf_top #(
  parameter int RATE_W = 10,
  parameter int LVL_W  = 6,
  parameter int CNT_W  = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              vid_clk,
  input  wire logic              line_tick,
  input  wire logic              fifo_word_pop,
  input  wire logic              fifo_fill_done,
  output logic                   refill_req,
  output logic                   ac_bias,
  output rpf_pkg::rpf_color_e    color_mode,
  output rpf_pkg::rpf_blink_e    blink_mode,
  output rpf_pkg::rpf_shift_e    shift_mode,
  output rpf_pkg::rpf_bpp_e      scan_bpp,
  output logic                   red_blue_order,
  output logic                   half_screen_split,
  output logic                   video_on,
  input  wire logic              norm_vsync,
  input  wire logic              norm_hsync,
  input  wire logic              norm_blank,
  input  wire logic [17:0]       norm_pix,
  input  wire logic              norm_sclk,
  input  wire logic              vert_sync_pin_in,
  output logic                   vert_sync_pin_out,
  output logic                   vert_sync_pin_oe,
  input  wire logic              hsync_pin_in,
  output logic                   hsync_pin_out,
  output logic                   hsync_pin_oe,
  input  wire logic              blank_pin_in,
  output logic                   blank_pin_out,
  output logic                   blank_pin_oe,
  input  wire logic [17:0]       pix_pin_in,
  output logic [17:0]            pix_pin_out,
  output logic [17:0]            pix_pin_oe,
  output logic                   shift_clk_pin_out,
  output logic                   shift_clk_pin_oe
);
  import rpf_pkg::*;

  if (RATE_W < 1 || RATE_W > 16) begin : g_bad_rate
    $error("RATE_W must be 1 to 16");
  end
  if (LVL_W < 5 || LVL_W > 16) begin : g_bad_lvl
    $error("LVL_W must be 5 to 16 to hold the reset level");
  end
  if (CNT_W < 1 || CNT_W > 4) begin : g_bad_cnt
    $error("CNT_W must be 1 to 4 to fit its register field");
  end

  typedef struct packed {
    logic [15:0]        pixmode;
    logic               en;
    logic               pif_on;
    logic [RATE_W-1:0]  rate;
    logic [LVL_W-1:0]   level;
    logic [CNT_W-1:0]   preload;
    logic [CNT_W-1:0]   strobe_begin_value;
    logic [7:0]         rd_byte;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [2:0]         vclk_sync;
    logic               vclk_f;
    logic [7:0]         d_s1;
    logic [7:0]         d_s2;
    logic [7:0]         d_s3;
    logic [7:0]         d_f;
    logic [RATE_W-1:0]  line_cnt;
    logic               ac_bias;
    logic [LVL_W-1:0]   pop_cnt;
    logic               refill_req;
    logic               start;
    logic               start_rd;
    logic [7:0]         start_byte;
    logic               vs_out;
    logic               vs_oe;
    logic               hs_out;
    logic               hs_oe;
    logic               bl_out;
    logic               bl_oe;
    logic [17:0]        px_out;
    logic [17:0]        px_oe;
    logic               sclk_out;
    logic               sclk_oe;
    rpf_color_e         color;
    rpf_blink_e         blink;
    rpf_shift_e         shift;
    rpf_bpp_e           bpp;
  } rpf_top_s;

  rpf_top_s st;
  rpf_top_s next_st;

  rpf_panel_if #(.CNT_W(CNT_W)) pif ();

  rpf_panel_port #(.CNT_W(CNT_W)) u_port (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pp      (pif.port)
  );

  function automatic rpf_color_e dec_color(input logic [3:0] c);
    if (c[3])                return RPF_CLR_GRAY;
    else if (c[2:0] == 3'h6) return RPF_CLR_555;
    else if (c == 4'h0)      return RPF_CLR_LUT;
    else if (c == 4'h4)      return RPF_CLR_888;
    else if (c == 4'h5)      return RPF_CLR_565;
    else                     return RPF_CLR_RSVD;
  endfunction

  function automatic rpf_blink_e dec_blink(input logic [3:0] m);
    case (m)
      4'h0:    return RPF_BL_OFF;
      4'h1:    return RPF_BL_AND;
      4'h2:    return RPF_BL_OR;
      4'h3:    return RPF_BL_XOR;
      4'h4:    return RPF_BL_BKGND;
      4'h5:    return RPF_BL_OFS_SINGLE;
      4'h6:    return RPF_BL_OFS_888;
      4'hc:    return RPF_BL_DIM_SINGLE;
      4'hd:    return RPF_BL_BRIGHT_SINGLE;
      4'he:    return RPF_BL_DIM_888;
      4'hf:    return RPF_BL_BRIGHT_888;
      default: return RPF_BL_UNDEF;
    endcase
  endfunction

  function automatic rpf_shift_e dec_shift(input logic [2:0] s);
    case (s)
      3'h1:    return RPF_SH_1PIX18;
      3'h2:    return RPF_SH_2PIX9;
      3'h3:    return RPF_SH_4PIX4;
      3'h4:    return RPF_SH_8PIX2;
      3'h5:    return RPF_SH_PACK3;
      3'h6:    return RPF_SH_PACK3_DUAL;
      default: return RPF_SH_1PIX24;
    endcase
  endfunction

  // Own depth field only; the drawing unit keeps its own setting
  function automatic rpf_bpp_e dec_bpp(input logic [2:0] p);
    case (p)
      3'h0:    return RPF_BPP_OFF;
      3'h1:    return RPF_BPP_4;
      3'h2:    return RPF_BPP_8;
      3'h4:    return RPF_BPP_16;
      3'h6:    return RPF_BPP_24P;
      3'h7:    return RPF_BPP_32;
      default: return RPF_BPP_BAD;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [31:0] a);
    return a == `RPF_ADDR_ATTR || a == `RPF_ADDR_PIXMODE || a == `RPF_ADDR_PANEL_OUT
        || a == `RPF_ADDR_PANEL_CTL || a == `RPF_ADDR_BIAS_RATE || a == `RPF_ADDR_FIFOLVL;
  endfunction

  logic setup;
  logic wr;
  logic [7:0] pb;

  always_comb begin
    next_st = st;
    setup = psel && !penable;
    wr = psel && penable && pwrite && st.pready && !st.pslverr;
    pb = st.start_byte;

    // APB: one wait-free access phase, answer prepared in setup
    next_st.pready  = setup;
    next_st.pslverr = setup && !addr_hit(paddr);
    if (setup) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        `RPF_ADDR_ATTR: begin
          next_st.prdata[`RPF_ATTR_EN_BIT]  = st.en;
          next_st.prdata[`RPF_ATTR_PIF_BIT] = st.pif_on;
        end
        `RPF_ADDR_PIXMODE:   next_st.prdata[15:0] = st.pixmode;
        `RPF_ADDR_PANEL_CTL: begin
          next_st.prdata[`RPF_PC_CNT_LSB +: CNT_W]        = st.preload;
          next_st.prdata[`RPF_PC_STRB_BEGIN_LSB +: CNT_W] = st.strobe_begin_value;
          next_st.prdata[7:0]                             = st.rd_byte;
        end
        `RPF_ADDR_BIAS_RATE: next_st.prdata[RATE_W-1:0] = st.rate;
        `RPF_ADDR_FIFOLVL:   next_st.prdata[LVL_W-1:0]  = st.level;
        default:             next_st.prdata = 32'h0000_0000;
      endcase
    end

    next_st.start = 1'b0;
    if (wr) begin
      case (paddr)
        `RPF_ADDR_ATTR: begin
          next_st.en     = pwdata[`RPF_ATTR_EN_BIT];
          next_st.pif_on = pwdata[`RPF_ATTR_PIF_BIT];
        end
        // Bit 16 and above are not stored
        `RPF_ADDR_PIXMODE:   next_st.pixmode = pwdata[15:0];
        `RPF_ADDR_PANEL_OUT: begin
          if (st.pif_on && !pif.busy && !st.start) begin
            next_st.start      = 1'b1;
            next_st.start_rd   = pwdata[`RPF_PO_DIR_BIT];
            next_st.start_byte = pwdata[7:0];
          end
        end
        `RPF_ADDR_PANEL_CTL: begin
          next_st.preload            = pwdata[`RPF_PC_CNT_LSB +: CNT_W];
          next_st.strobe_begin_value = pwdata[`RPF_PC_STRB_BEGIN_LSB +: CNT_W];
        end
        `RPF_ADDR_BIAS_RATE: next_st.rate  = pwdata[RATE_W-1:0];
        `RPF_ADDR_FIFOLVL:   next_st.level = pwdata[LVL_W-1:0];
        default:             next_st.en    = st.en;
      endcase
    end
    if (pif.rd_valid) begin
      next_st.rd_byte = pif.rd_byte;
    end

    // Mode decode, registered once per cycle from the stored field
    next_st.color = dec_color(st.pixmode[`RPF_PM_C_LSB +: 4]);
    next_st.blink = dec_blink(st.pixmode[`RPF_PM_M_LSB +: 4]);
    next_st.shift = dec_shift(st.pixmode[`RPF_PM_S_LSB +: 3]);
    next_st.bpp   = dec_bpp(st.pixmode[`RPF_PM_P_LSB +: 3]);

    // Pin inputs: three stages, a change counts once stages two and three agree
    next_st.vclk_sync = {st.vclk_sync[1:0], vid_clk};
    if (st.vclk_sync[1] == st.vclk_sync[2]) begin
      next_st.vclk_f = st.vclk_sync[2];
    end
    next_st.d_s1 = {vert_sync_pin_in, hsync_pin_in, blank_pin_in, pix_pin_in[17],
                    pix_pin_in[3], pix_pin_in[2:0]};
    next_st.d_s2 = st.d_s1;
    next_st.d_s3 = st.d_s2;
    for (int i = 0; i < 8; i++) begin
      if (st.d_s2[i] == st.d_s3[i]) begin
        next_st.d_f[i] = st.d_s3[i];
      end
    end

    // AC bias counts horizontal lines
    if (line_tick) begin
      if (st.line_cnt == st.rate) begin
        next_st.ac_bias  = !st.ac_bias;
        next_st.line_cnt = '0;
      end else begin
        next_st.line_cnt = st.line_cnt + 1'b1;
      end
    end

    // Refill request; a word popped on the delivery cycle still counts
    if (!st.en) begin
      next_st.pop_cnt    = '0;
      next_st.refill_req = 1'b0;
    end else begin
      if (fifo_fill_done) begin
        next_st.refill_req = 1'b0;
        next_st.pop_cnt    = '0;
      end
      if (fifo_word_pop) begin
        next_st.pop_cnt = (fifo_fill_done ? '0 : st.pop_cnt) + 1'b1;
        if (next_st.pop_cnt >= st.level || st.refill_req && !fifo_fill_done) begin
          next_st.refill_req = 1'b1;
        end
      end
    end

    // Pin muxing
    next_st.vs_out   = norm_vsync;
    next_st.hs_out   = norm_hsync;
    next_st.bl_out   = norm_blank;
    next_st.px_out   = norm_pix;
    next_st.sclk_out = norm_sclk;
    next_st.vs_oe    = 1'b1;
    next_st.hs_oe    = 1'b1;
    next_st.bl_oe    = 1'b1;
    next_st.px_oe    = '1;
    next_st.sclk_oe  = 1'b1;
    if (st.pif_on) begin
      pb = pif.drive ? st.start_byte : 8'h00;
      next_st.vs_out     = pb[7];
      next_st.hs_out     = pb[6];
      next_st.bl_out     = pb[5];
      next_st.px_out[17] = pb[4];
      next_st.px_out[3]  = pb[3];
      next_st.px_out[2:0] = pb[2:0];
      next_st.vs_oe      = pif.drive;
      next_st.hs_oe      = pif.drive;
      next_st.bl_oe      = pif.drive;
      next_st.px_oe[17]  = pif.drive;
      next_st.px_oe[3]   = pif.drive;
      next_st.px_oe[2:0] = {3{pif.drive}};
      next_st.sclk_out   = pif.strobe;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '{pixmode: `RPF_PIXMODE_RST, rate: RATE_W'(`RPF_BIAS_RATE_RST),
              level: LVL_W'(`RPF_FIFOLVL_RST), preload: CNT_W'(`RPF_PANEL_CTL_RST),
              strobe_begin_value: CNT_W'(`RPF_PANEL_CTL_RST), color: RPF_CLR_LUT,
              blink: RPF_BL_OFF, shift: RPF_SH_1PIX24, bpp: RPF_BPP_OFF, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Step the panel counter on each filtered rising edge of the video clock
  assign pif.start    = st.start;
  assign pif.is_read  = st.start_rd;
  assign pif.wr_byte  = st.start_byte;
  assign pif.preload  = st.preload;
  assign pif.strobe_begin_value = st.strobe_begin_value;
  assign pif.step     = (st.vclk_sync[1] == st.vclk_sync[2]) && st.vclk_sync[2] && !st.vclk_f;
  assign pif.pin_byte = st.d_f;

  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign refill_req        = st.refill_req;
  assign ac_bias           = st.ac_bias;
  assign color_mode        = st.color;
  assign blink_mode        = st.blink;
  assign shift_mode        = st.shift;
  assign scan_bpp          = st.bpp;
  assign red_blue_order    = st.pixmode[`RPF_PM_RB_BIT];
  assign half_screen_split = st.pixmode[`RPF_PM_DS_BIT];
  assign video_on          = st.en;
  assign vert_sync_pin_out = st.vs_out;
  assign vert_sync_pin_oe  = st.vs_oe;
  assign hsync_pin_out     = st.hs_out;
  assign hsync_pin_oe      = st.hs_oe;
  assign blank_pin_out     = st.bl_out;
  assign blank_pin_oe      = st.bl_oe;
  assign pix_pin_out       = st.px_out;
  assign pix_pin_oe        = st.px_oe;
  assign shift_clk_pin_out = st.sclk_out;
  assign shift_clk_pin_oe  = st.sclk_oe;
endmodule // rpf_top

// *** test/rpf_checker.sv ***
// Port-level assertions for the raster pixel format block
`timescale 1ns/10ps
module rpf_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_tick,
  input wire logic        ac_bias,
  input wire logic        fifo_word_pop,
  input wire logic        fifo_fill_done,
  input wire logic        refill_req,
  input wire logic        video_on,
  input wire logic [17:0] norm_pix,
  input wire logic [17:0] pix_pin_out,
  input wire logic [17:0] pix_pin_oe,
  input wire logic        shift_clk_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_BIAS_TICK: assert property (ac_bias != $past(ac_bias) |-> $past(line_tick))
    else $error("bias moved without a line");
  AST_REFILL_RISE: assert property ($rose(refill_req) |-> $past(fifo_word_pop))
    else $error("refill rose without a pop");
  AST_REFILL_HOLD: assert property (refill_req && !fifo_fill_done && video_on
    ##1 video_on |-> refill_req)
    else $error("refill dropped early");
  AST_REFILL_OFF: assert property (!video_on ##1 !video_on |-> !refill_req)
    else $error("refill while video off");
  AST_PIN_NORMAL: assert property (!$past(rst) |-> pix_pin_oe[10]
    && pix_pin_out[10] == $past(norm_pix[10]))
    else $error("unmapped pin not normal");
  AST_SCLK_OE: assert property (!$past(rst) |-> shift_clk_pin_oe)
    else $error("shift clock pin released");
  COV_ERR: cover property (pslverr);
  COV_REFILL: cover property ($rose(refill_req));
  COV_BIAS: cover property ($rose(ac_bias));
endmodule // rpf_checker

bind rpf_top rpf_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .line_tick(line_tick), .ac_bias(ac_bias),
  .fifo_word_pop(fifo_word_pop), .fifo_fill_done(fifo_fill_done),
  .refill_req(refill_req), .video_on(video_on), .norm_pix(norm_pix),
  .pix_pin_out(pix_pin_out), .pix_pin_oe(pix_pin_oe), .shift_clk_pin_oe(shift_clk_pin_oe)
);

// *** test/rpf_panel_model.sv ***
// Byte-wide panel controller on the remapped pins
`timescale 1ns/10ps
module rpf_panel_model (
  input wire logic        strobe,
  input wire logic [7:0]  dout,
  input wire logic [7:0]  doe,
  input wire logic [7:0]  rd_val,
  input wire logic        rd_en,
  output logic [7:0]      wire_b,
  output logic [7:0]      got
);
  // Panel answers only while its read line is set; released lines invert
  always_comb for (int i = 0; i < 8; i++)
    wire_b[i] = doe[i] ? dout[i] : (rd_en ? rd_val[i] : ~dout[i]);
  always @(negedge strobe) if (&doe) got = dout;
endmodule // rpf_panel_model

// *** test/tb_top.sv ***
// Self-checking bench for the raster pixel format block
`timescale 1ns/10ps
`include "rpf_defs.svh"
module tb_top;
  import rpf_pkg::*;
  logic ref_clk = 0, rst = 1, vid_clk = 0, psel = 0, penable = 0, pwrite = 0;
  logic line_tick = 0, fifo_word_pop = 0, fifo_fill_done = 0, rd_en = 0, e;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic pready, pslverr, refill_req, ac_bias, red_blue_order, half_screen_split, video_on;
  rpf_color_e color_mode;
  rpf_blink_e blink_mode;
  rpf_shift_e shift_mode;
  rpf_bpp_e scan_bpp;
  logic [17:0] norm_pix = 0, pix_pin_out, pix_pin_oe;
  logic [3:0] nc = 0;
  logic vs_o, vs_e, hs_o, hs_e, bl_o, bl_e, sc_o, sc_e;
  logic [7:0] dout, doe, dwire, got, b, rd_val = 0;
  logic [15:0] v;
  int num_errors = 0, check_count = 0, lvl, cnt, rate;
  always #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #80 vid_clk = ~vid_clk;
  end
  always @(posedge ref_clk) {nc, norm_pix} <= 22'($urandom);
  assign dout = {vs_o, hs_o, bl_o, pix_pin_out[17], pix_pin_out[3], pix_pin_out[2:0]};
  assign doe = {vs_e, hs_e, bl_e, pix_pin_oe[17], pix_pin_oe[3], pix_pin_oe[2:0]};
  rpf_top uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vid_clk(vid_clk), .line_tick(line_tick),
    .fifo_word_pop(fifo_word_pop), .fifo_fill_done(fifo_fill_done),
    .refill_req(refill_req), .ac_bias(ac_bias), .color_mode(color_mode),
    .blink_mode(blink_mode), .shift_mode(shift_mode), .scan_bpp(scan_bpp),
    .red_blue_order(red_blue_order), .half_screen_split(half_screen_split),
    .video_on(video_on), .norm_vsync(nc[0]), .norm_hsync(nc[1]), .norm_blank(nc[2]),
    .norm_pix(norm_pix), .norm_sclk(nc[3]), .vert_sync_pin_in(dwire[7]),
    .vert_sync_pin_out(vs_o), .vert_sync_pin_oe(vs_e), .hsync_pin_in(dwire[6]),
    .hsync_pin_out(hs_o), .hsync_pin_oe(hs_e), .blank_pin_in(dwire[5]),
    .blank_pin_out(bl_o), .blank_pin_oe(bl_e),
    .pix_pin_in({dwire[4], pix_pin_out[16:4], dwire[3], dwire[2:0]}),
    .pix_pin_out(pix_pin_out), .pix_pin_oe(pix_pin_oe),
    .shift_clk_pin_out(sc_o), .shift_clk_pin_oe(sc_e));
  rpf_panel_model pnl (.strobe(sc_o), .dout(dout), .doe(doe), .rd_val(rd_val),
    .rd_en(rd_en), .wire_b(dwire), .got(got));
  function rpf_color_e ec(input logic [3:0] c);
    if (c[3]) return RPF_CLR_GRAY;
    if (c == 0) return RPF_CLR_LUT;
    if (c == 4) return RPF_CLR_888;
    if (c == 5) return RPF_CLR_565;
    return (c[2:0] == 6) ? RPF_CLR_555 : RPF_CLR_RSVD;
  endfunction
  function rpf_blink_e eb(input logic [3:0] m);
    if (m < 7) return rpf_blink_e'(m);
    return (m >= 12) ? rpf_blink_e'(m - 5) : RPF_BL_UNDEF;
  endfunction
  function rpf_bpp_e ebp(input logic [2:0] p);
    case (p)
      0: return RPF_BPP_OFF;
      1: return RPF_BPP_4;
      2: return RPF_BPP_8;
      4: return RPF_BPP_16;
      6: return RPF_BPP_24P;
      7: return RPF_BPP_32;
      default: return RPF_BPP_BAD;
    endcase
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    apb(0, a, 0);
    chk(r, x);
    chk(e, xe);
  endtask
  // Kind 0 line, 1 pop, 2 delivery, 3 pop together with delivery
  task pulse(input int w);
    @(posedge ref_clk);
    line_tick <= (w == 0);
    fifo_word_pop <= (w == 1 || w == 3);
    fifo_fill_done <= (w >= 2);
    @(posedge ref_clk);
    {line_tick, fifo_word_pop, fifo_fill_done} <= 3'b000;
    repeat (2) @(posedge ref_clk);
  endtask
  task wrap_up;
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200_000;
    num_errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h3050bb7e));
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    rd(`RPF_ADDR_PIXMODE, 0, 0);
    rd(`RPF_ADDR_BIAS_RATE, 0, 0);
    rd(`RPF_ADDR_FIFOLVL, 32'h10, 0);
    rd(`RPF_ADDR_PANEL_OUT, 0, 0);
    rd(32'h8003_0100, 0, 1);
    for (int i = 0; i < 16; i++) begin
      v = {2'($urandom), 4'(i), 4'(i), 3'(i), 3'(i)};
      apb(1, `RPF_ADDR_PIXMODE, {15'($urandom), 1'b0, v});
      rd(`RPF_ADDR_PIXMODE, {16'h0, v}, 0);
      chk({red_blue_order, half_screen_split, color_mode, blink_mode, shift_mode, scan_bpp},
        {v[15:14], ec(v[13:10]), eb(v[9:6]), (v[5:3] == 7) ? RPF_SH_1PIX24
        : rpf_shift_e'(v[5:3]), ebp(v[2:0])});
    end
    rate = $urandom_range(3, 1);
    apb(1, `RPF_ADDR_ATTR, 1);
    apb(1, `RPF_ADDR_BIAS_RATE, rate);
    for (int k = 1; k <= 12; k++) begin
      pulse(0);
      chk(ac_bias, (k / (rate + 1)) % 2);
    end
    lvl = $urandom_range(4, 2);
    apb(1, `RPF_ADDR_FIFOLVL, lvl);
    cnt = 0;
    repeat (lvl + 1) begin
      pulse(1);
      cnt++;
      chk(refill_req, cnt >= lvl);
    end
    pulse(2);
    chk(refill_req, 0);
    repeat (lvl) pulse(1);
    chk(refill_req, 1);
    pulse(3);
    chk(refill_req, 0);
    repeat (lvl - 1) pulse(1);
    chk(refill_req, 1);
    apb(1, `RPF_ADDR_ATTR, 0);
    repeat (2) @(posedge ref_clk);
    chk({video_on, refill_req}, 0);
    apb(1, `RPF_ADDR_PANEL_CTL, 32'h0023_0000);
    apb(1, `RPF_ADDR_PANEL_OUT, 32'h0000_00ff);
    apb(1, `RPF_ADDR_ATTR, 32'h2001);
    repeat (2) @(posedge ref_clk);
    chk({doe, sc_o}, 0);
    for (int j = 0; j < 2; j++) begin
      b = 8'($urandom);
      rd_val <= 8'($urandom);
      rd_en <= j[0];
      apb(1, `RPF_ADDR_PANEL_OUT, {23'h0, j[0], b});
      repeat (160) @(posedge ref_clk);
      if (j == 0) chk(got, b);
      else rd(`RPF_ADDR_PANEL_CTL, {16'h0023, 8'h0, rd_val}, 0);
    end
    wrap_up;
  end
endmodule // tb_top
